// file: rtl/csf_core.sv
// Function
// - sync enable makes strobe reset modulator, filter
// - sync restarts sequencer at lowest enabled channel
// - falling strobe holds filter in reset
// - leave reset on falling edge after rise
// - single channel: rising strobe starts one conversion
// - alternate mode bit selects alternate sync
// - alternate: finish, advance, wait for high; code still pulses filter_rst for one clock at the falling strobe
// - alternate: done and data update unaffected
// - range faults set flag, clamp code
// - conversion flag clears only when condition gone
// - checksum fault set, cleared by status read
// - monitor enabled: config change sets flag
// - monitor bit written zero clears change flag
// - two-bit field selects fault pin mode
// - fault output: inverted OR of flags
// - fault input: inverted pin into conversion flag
// - general output drives fault pin level bit
// - append status byte; low nibble is channel
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module csf_core #(
	parameter int SETTLE = csf_pkg::CSF_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire csf_pkg::csf_wb_req_t wb_req,
	output csf_pkg::csf_wb_rsp_t wb_rsp,
	input wire logic align_n,
	input wire logic fault_in,
	output csf_pkg::csf_pin_drv_t fault_drv,
	input wire logic [23:0] sample,
	output logic done_n,
	output logic [31:0] result,
	output logic result_vld,
	output logic [3:0] active_ch,
	output logic filter_rst
);
	import csf_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] first_from(input logic [15:0] en, input logic [3:0] start);
		logic [3:0] idx;
		logic found;
		first_from = start;
		found = 1'b0;
		for (int i = 0; i < CSF_NCH; i++) begin
			idx = start + i[3:0];
			if (!found && en[idx]) begin
				first_from = idx;
				found = 1'b1;
			end
		end
	endfunction : first_from

	function automatic logic [7:0] fold8(input logic [31:0] v);
		fold8 = v[31:24] ^ v[23:16] ^ v[15:8] ^ v[7:0];
	endfunction : fold8

	localparam logic [7:0] SETTLE_N = 8'(SETTLE - 1);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] align_sq;
	logic [1:0] fin_sq;
	logic align_prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			align_sq <= 2'b11;
			fin_sq <= 2'b11;
			align_prev_q <= 1'b1;
		end else begin
			align_sq <= {align_sq[0], align_n};
			fin_sq <= {fin_sq[0], fault_in};
			align_prev_q <= align_sq[1];
		end
	end

	wire align_lvl = align_sq[1];
	wire fin_lvl = fin_sq[1];

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [2:0] interface_mode_register_q;
	logic [3:0] pinctl_q;
	logic [15:0] chen_q;
	logic [31:0] setup_q;
	logic [23:0] data_q;
	logic conv_err_q;
	logic cks_err_q;
	logic reg_err_q;
	logic [7:0] cfg_sum_q;
	logic ack_q;
	logic [31:0] rdat_q;

	wire alt_mode = interface_mode_register_q[CSF_IF_ALT];
	wire mon_en = interface_mode_register_q[CSF_IF_MON];
	wire append_en = interface_mode_register_q[CSF_IF_APPEND];
	wire sync_en = pinctl_q[CSF_PC_SYNC_EN];
	wire pin_level = pinctl_q[CSF_PC_LEVEL];
	csf_pin_mode_t pin_mode;
	assign pin_mode = csf_pin_mode_t'(pinctl_q[CSF_PC_FUNC_LO +: 2]);

	wire bus_req = wb_req.cyc && wb_req.stb && !ack_q;
	wire bus_wr = bus_req && wb_req.we;
	wire bus_rd = bus_req && !wb_req.we;
	wire wr_if = bus_wr && wb_req.adr == CSF_ADR_INTERFACE_MODE_REGISTER && wb_req.sel[0];
	wire wr_pc = bus_wr && wb_req.adr == CSF_ADR_PINCTL && wb_req.sel[0];
	wire wr_ch = bus_wr && wb_req.adr == CSF_ADR_CHEN;
	wire wr_su = bus_wr && wb_req.adr == CSF_ADR_SETUP;
	wire wr_ev = bus_wr && wb_req.adr == CSF_ADR_EVENT && wb_req.sel[0];
	wire rd_st = bus_rd && wb_req.adr == CSF_ADR_STATUS;

	wire [15:0] chen_d = {wb_req.sel[1] ? wb_req.dat[15:8] : chen_q[15:8],
		wb_req.sel[0] ? wb_req.dat[7:0] : chen_q[7:0]};
	logic [31:0] setup_d;
	always_comb begin
		setup_d = setup_q;
		for (int b = 0; b < 4; b++) begin
			if (wb_req.sel[b])
				setup_d[8*b +: 8] = wb_req.dat[8*b +: 8];
		end
	end

	// ------------------------------------------------------------
	// sequencer and conversion engine
	// ------------------------------------------------------------
	csf_state_t state_q;
	logic [7:0] cnt_q;
	logic [3:0] ch_q;

	wire fall = sync_en && align_prev_q && !align_lvl;
	wire rise = sync_en && !align_prev_q && align_lvl;
	wire held = sync_en && !align_lvl;
	wire multi = (chen_q & (chen_q - 16'd1)) != 16'd0;
	wire [3:0] first_ch = first_from(chen_q, 4'd0);
	wire [3:0] next_ch = first_from(chen_q, ch_q + 4'd1);
	wire conv_end = state_q == CSF_ST_RUN && cnt_q == SETTLE_N;

	// range detection on the finished sample
	wire ovr = sample == 24'hFF_FFFF;
	wire uvr = sample == 24'h00_0000;
	logic in_ovv_q;
	logic in_uvv_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= CSF_ST_RUN;
			cnt_q <= 8'h00;
			ch_q <= 4'h0;
		end else begin
			unique case (state_q)
				CSF_ST_RUN: begin
					if (fall && !alt_mode) begin
						state_q <= CSF_ST_HOLD;
						ch_q <= first_ch;
						cnt_q <= 8'h00;
					end else if (conv_end) begin
						cnt_q <= 8'h00;
						ch_q <= next_ch;
						if (alt_mode && held)
							state_q <= CSF_ST_WAIT;
						else if (sync_en && !alt_mode && !multi)
							state_q <= CSF_ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				CSF_ST_HOLD: begin
					// filter released two clocks after the rise: falling-edge equivalent
					if (rise)
						state_q <= CSF_ST_RUN;
					else if (!sync_en)
						state_q <= CSF_ST_RUN;
				end
				CSF_ST_WAIT: begin
					if (!held)
						state_q <= CSF_ST_RUN;
				end
				CSF_ST_IDLE: begin
					if (!sync_en || multi)
						state_q <= CSF_ST_RUN;
					else if (fall)
						state_q <= CSF_ST_HOLD;
				end
				default: state_q <= CSF_ST_RUN;
			endcase
		end
	end

	// ------------------------------------------------------------
	// fault flags
	// ------------------------------------------------------------
	wire ext_fault = pin_mode == CSF_PIN_IN && !fin_lvl;
	wire ev_ovr = wr_ev && wb_req.dat[CSF_EV_OVR];
	wire ev_uvr = wr_ev && wb_req.dat[CSF_EV_UVR];
	wire cks_bad = wr_ev && wb_req.dat[CSF_EV_CKSUM];
	wire [7:0] cfg_sum = fold8({chen_q, 12'h000, pinctl_q}) ^ fold8(setup_q);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interface_mode_register_q <= 3'b000;
			pinctl_q <= 4'b0000;
			chen_q <= CSF_CHEN_RST;
			setup_q <= CSF_SETUP_RST;
			in_ovv_q <= 1'b0;
			in_uvv_q <= 1'b0;
			conv_err_q <= 1'b0;
			cks_err_q <= 1'b0;
			reg_err_q <= 1'b0;
			cfg_sum_q <= 8'h00;
		end else begin
			if (wr_if)
				interface_mode_register_q <= wb_req.dat[2:0];
			if (wr_pc)
				pinctl_q <= wb_req.dat[3:0];
			if (wr_ch)
				chen_q <= chen_d;
			if (wr_su)
				setup_q <= setup_d;
			if (wr_ev) begin
				in_ovv_q <= ev_ovr;
				in_uvv_q <= ev_uvr;
			end
			// sticky only while the condition lasts, data reads do not touch it
			conv_err_q <= in_ovv_q || in_uvv_q || ext_fault
				|| (conv_end && (ovr || uvr));
			if (cks_bad)
				cks_err_q <= 1'b1;
			else if (rd_st)
				cks_err_q <= 1'b0;
			if (!mon_en) begin
				reg_err_q <= 1'b0;
				cfg_sum_q <= cfg_sum;
			end else if (cfg_sum != cfg_sum_q) begin
				reg_err_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// result path
	// ------------------------------------------------------------
	wire [7:0] status_byte = {done_n, conv_err_q, cks_err_q, reg_err_q, ch_q};
	wire [23:0] code = in_ovv_q ? 24'hFF_FFFF : in_uvv_q ? 24'h00_0000 : sample;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_q <= 24'h00_0000;
			done_n <= 1'b1;
			result <= 32'h0000_0000;
			result_vld <= 1'b0;
			active_ch <= 4'h0;
			filter_rst <= 1'b0;
		end else begin
			result_vld <= conv_end;
			active_ch <= ch_q;
			filter_rst <= state_q == CSF_ST_HOLD || fall;
			if (conv_end) begin
				data_q <= code;
				done_n <= 1'b0;
				// appended byte marks this result as ready, so its done bit reads low
				result <= append_en ? {code, 1'b0, status_byte[6:0]}
					: {8'h00, code};
			end else if (state_q == CSF_ST_HOLD || (bus_rd && wb_req.adr == CSF_ADR_DATA)) begin
				done_n <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// fault pin and bus answer
	// ------------------------------------------------------------
	wire any_err = conv_err_q || cks_err_q || reg_err_q;
	logic [31:0] rmux;
	always_comb begin
		unique case (wb_req.adr)
			CSF_ADR_STATUS: rmux = {24'h00_0000, status_byte};
			CSF_ADR_INTERFACE_MODE_REGISTER: rmux = {29'h0000_0000, interface_mode_register_q};
			CSF_ADR_PINCTL: rmux = {28'h000_0000, pinctl_q[3:2],
				pin_mode == CSF_PIN_IN ? fin_lvl : pin_level, pinctl_q[0]};
			CSF_ADR_CHEN: rmux = {16'h0000, chen_q};
			CSF_ADR_DATA: rmux = {8'h00, data_q};
			CSF_ADR_SETUP: rmux = setup_q;
			default: rmux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_drv <= '0;
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			unique case (pin_mode)
				CSF_PIN_OD: fault_drv <= '{o: 1'b0, oe: any_err};
				CSF_PIN_GPO: fault_drv <= '{o: pin_level, oe: 1'b1};
				default: fault_drv <= '0;
			endcase
			ack_q <= bus_req;
			rdat_q <= rmux;
		end
	end

	assign wb_rsp = '{dat: rdat_q, ack: ack_q};

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_fall_run;
		state_q == CSF_ST_RUN && fall && !alt_mode;
	endsequence

	AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (rst)
		s_fall_run |=> state_q == CSF_ST_HOLD ##1 filter_rst)
		else $error("filter not held after falling strobe");
	AST_SEQ_RESTART: assert property (@(posedge clk) disable iff (rst)
		s_fall_run |=> ch_q == $past(first_ch))
		else $error("sequencer not reset to first channel");
	AST_RELEASE: assert property (@(posedge clk) disable iff (rst)
		state_q == CSF_ST_HOLD && rise |=> state_q == CSF_ST_RUN ##1 !filter_rst)
		else $error("filter release late");
	AST_DISABLED: assert property (@(posedge clk) disable iff (rst)
		!sync_en && state_q == CSF_ST_RUN |=> state_q != CSF_ST_HOLD)
		else $error("strobe acted while disabled");
	AST_DONE: assert property (@(posedge clk) disable iff (rst)
		conv_end |=> !done_n && result_vld && data_q == $past(code))
		else $error("done or data missing after conversion");
	AST_CKSUM: assert property (@(posedge clk) disable iff (rst)
		cks_bad |=> cks_err_q [*2])
		else $error("checksum fault not held");
	AST_REGCLR: assert property (@(posedge clk) disable iff (rst)
		!mon_en |=> !reg_err_q)
		else $error("change flag not cleared");
	AST_FAULT_OD: assert property (@(posedge clk) disable iff (rst)
		pin_mode == CSF_PIN_OD && any_err |=> fault_drv.oe && !fault_drv.o)
		else $error("fault pin not pulled low");
	AST_GPO: assert property (@(posedge clk) disable iff (rst)
		pin_mode == CSF_PIN_GPO |=> fault_drv.oe && fault_drv.o == $past(pin_level))
		else $error("general output level wrong");
	AST_EXT: assert property (@(posedge clk) disable iff (rst)
		ext_fault |=> conv_err_q)
		else $error("external fault not merged");

endmodule : csf_core
`default_nettype wire

// file: rtl/csf_pkg.sv
`default_nettype none
package csf_pkg;

	// ------------------------------------------------------------
	// register map (word offsets are byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] CSF_ADR_STATUS = 8'h00;
	localparam logic [7:0] CSF_ADR_INTERFACE_MODE_REGISTER = 8'h04;
	localparam logic [7:0] CSF_ADR_PINCTL = 8'h08;
	localparam logic [7:0] CSF_ADR_CHEN = 8'h0C;
	localparam logic [7:0] CSF_ADR_DATA = 8'h10;
	localparam logic [7:0] CSF_ADR_SETUP = 8'h14;
	localparam logic [7:0] CSF_ADR_EVENT = 8'h18;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CSF_IF_ALT = 0;
	localparam int CSF_IF_MON = 1;
	localparam int CSF_IF_APPEND = 2;
	localparam int CSF_PC_SYNC_EN = 0;
	localparam int CSF_PC_LEVEL = 1;
	localparam int CSF_PC_FUNC_LO = 2;
	localparam int CSF_EV_CKSUM = 0;
	localparam int CSF_EV_OVR = 1;
	localparam int CSF_EV_UVR = 2;

	// ------------------------------------------------------------
	// reset values and counts
	// ------------------------------------------------------------
	localparam logic [15:0] CSF_CHEN_RST = 16'h0001;
	localparam logic [31:0] CSF_SETUP_RST = 32'h0000_0000;
	localparam int CSF_SETTLE_CYC = 16;
	localparam int CSF_NCH = 16;

	typedef enum logic [1:0] {
		CSF_PIN_OFF = 2'b00,
		CSF_PIN_IN = 2'b01,
		CSF_PIN_OD = 2'b10,
		CSF_PIN_GPO = 2'b11
	} csf_pin_mode_t;

	typedef enum logic [1:0] {
		CSF_ST_RUN = 2'b00,
		CSF_ST_HOLD = 2'b01,
		CSF_ST_WAIT = 2'b11,
		CSF_ST_IDLE = 2'b10
	} csf_state_t;

	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} csf_wb_req_t;

	typedef struct packed {
		logic [31:0] dat;
		logic ack;
	} csf_wb_rsp_t;

	typedef struct packed {
		logic o;
		logic oe;
	} csf_pin_drv_t;

endpackage : csf_pkg
`default_nettype wire

// file: sim/conversion_sync_and_fault_flags_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module conversion_sync_and_fault_flags_tb_top;
	import csf_pkg::*;
	localparam int ST = 8;
	localparam logic [8:0] ROWS [0:3] = '{9'h001, 9'h018, 9'h01D, 9'h011};
	logic clk, rst, hold_low, kick, ext_low, align_n, done_n, result_vld, filter_rst, hit;
	logic [7:0] len;
	logic [23:0] sample;
	logic [31:0] result, q, r1;
	logic [3:0] active_ch;
	csf_wb_req_t req;
	csf_wb_rsp_t rsp;
	csf_pin_drv_t fault_drv;
	int errors, n_compared, cycles, i;
	// pull-up on the pin when nobody drives it
	wire fault_pin = fault_drv.oe ? fault_drv.o : !ext_low;
	csf_host_model host_u (.clk(clk), .rst(rst), .hold_low(hold_low), .kick(kick), .len(len),
		.align_n(align_n));
	csf_core #(.SETTLE(ST)) dut_u (.clk(clk), .rst(rst), .wb_req(req), .wb_rsp(rsp),
		.align_n(align_n), .fault_in(fault_pin), .fault_drv(fault_drv), .sample(sample),
		.done_n(done_n), .result(result), .result_vld(result_vld), .active_ch(active_ch),
		.filter_rst(filter_rst));
	// ----
	// helpers
	// ----
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: %s got %h", $time, m, got);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{adr: a, dat: d, sel: 4'hF, we: we, cyc: 1'b1, stb: 1'b1};
		@(posedge clk);
		// ack is sampled at the rising edge; if it never comes, only the bench timeout ends this wait
		while (rsp.ack !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		chk(n, 1, "ack latency");
		q = rsp.dat;
		req <= '0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q & m, e, "read");
	endtask : rd
	task automatic wait_for(input int which, input int lim);
		int n;
		hit = 1'b0;
		for (n = 0; n < lim && !hit; n++) begin
			@(negedge clk);
			case (which)
				0: hit = (filter_rst === 1'b1);
				1: hit = (filter_rst === 1'b0);
				default: hit = (result_vld === 1'b1);
			endcase
		end
	endtask : wait_for
	initial begin
		clk = 1'b0;
		forever #25 clk = !clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			errors++;
			wrap_up();
		end
	end
	// ----
	// tests
	// ----
	initial begin
		rst = 1'b1;
		req = '0;
		{hold_low, kick, ext_low} = 3'b000;
		len = 8'h03;
		sample = 24'h40_0000;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		chk(done_n, 1'b1, "done_n at reset");
		rd(CSF_ADR_CHEN, 32'h0000_FFFF, 32'h0000_0001);
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			wb(1'b1, CSF_ADR_PINCTL, {24'h00_0000, ROWS[i][8:1]});
			repeat (4) @(posedge clk);
			chk(fault_pin, ROWS[i][0], "pin mode");
		end
		$display("pin table done");
		wb(1'b1, CSF_ADR_EVENT, 32'h0000_0002);
		repeat (4 * ST) @(posedge clk);
		chk(fault_pin, 1'b0, "fault out");
		rd(CSF_ADR_DATA, 32'h00FF_FFFF, 32'h00FF_FFFF);
		rd(CSF_ADR_STATUS, 32'h0000_0040, 32'h0000_0040);
		wb(1'b1, CSF_ADR_EVENT, 32'h0000_0004);
		repeat (4 * ST) @(posedge clk);
		rd(CSF_ADR_DATA, 32'h00FF_FFFF, 32'h0000_0000);
		rd(CSF_ADR_STATUS, 32'h0000_0040, 32'h0000_0040);
		wb(1'b1, CSF_ADR_EVENT, 32'h0000_0000);
		repeat (4 * ST) @(posedge clk);
		rd(CSF_ADR_STATUS, 32'h0000_0040, 32'h0000_0000);
		wb(1'b1, CSF_ADR_EVENT, 32'h0000_0001);
		wb(1'b1, CSF_ADR_EVENT, 32'h0000_0000);
		rd(CSF_ADR_STATUS, 32'h0000_0020, 32'h0000_0020);
		rd(CSF_ADR_STATUS, 32'h0000_0020, 32'h0000_0000);
		wb(1'b1, CSF_ADR_INTERFACE_MODE_REGISTER, 32'h0000_0002);
		wb(1'b1, CSF_ADR_SETUP, 32'h0000_00A5);
		rd(CSF_ADR_STATUS, 32'h0000_0010, 32'h0000_0010);
		wb(1'b1, CSF_ADR_INTERFACE_MODE_REGISTER, 32'h0000_0000);
		rd(CSF_ADR_STATUS, 32'h0000_0010, 32'h0000_0000);
		wb(1'b1, CSF_ADR_PINCTL, 32'h0000_0004);
		ext_low <= 1'b1;
		repeat (4 * ST) @(posedge clk);
		rd(CSF_ADR_STATUS, 32'h0000_0040, 32'h0000_0040);
		rd(CSF_ADR_PINCTL, 32'h0000_0002, 32'h0000_0000);
		ext_low <= 1'b0;
		$display("fault flag tests done");
		wb(1'b1, CSF_ADR_PINCTL, 32'h0000_0000);
		kick <= 1'b1;
		@(posedge clk) kick <= 1'b0;
		wait_for(0, 12);
		chk(hit, 1'b0, "strobe with sync off");
		wb(1'b1, CSF_ADR_PINCTL, 32'h0000_0001);
		hold_low <= 1'b1;
		wait_for(0, 10);
		chk(hit, 1'b1, "filter reset");
		rd(CSF_ADR_CHEN, 32'h0000_FFFF, 32'h0000_0001);
		@(negedge clk);
		chk(filter_rst, 1'b1, "held in reset");
		@(posedge clk) hold_low <= 1'b0;
		wait_for(1, 8);
		chk(hit, 1'b1, "reset release");
		wait_for(2, ST + 6);
		chk({hit, done_n}, 2'b10, "single start");
		wait_for(2, 3 * ST);
		chk(hit, 1'b0, "one conversion only");
		$display("normal sync done");
		wb(1'b1, CSF_ADR_CHEN, 32'h0000_0014);
		wb(1'b1, CSF_ADR_INTERFACE_MODE_REGISTER, 32'h0000_0004);
		kick <= 1'b1;
		@(posedge clk) kick <= 1'b0;
		wait_for(0, 10);
		wait_for(1, 10);
		chk(active_ch, 4'h2, "sequencer restart");
		wait_for(2, ST + 6);
		chk(result, {sample, 8'h02}, "appended status");
		// alternate mode only with several channels on
		wb(1'b1, CSF_ADR_INTERFACE_MODE_REGISTER, 32'h0000_0005);
		wait_for(2, ST + 6);
		r1 = result;
		@(posedge clk) hold_low <= 1'b1;
		wait_for(2, ST + 8);
		chk(hit, 1'b1, "finish under low");
		wait_for(2, 3 * ST);
		chk(hit, 1'b0, "waits for high");
		@(posedge clk) hold_low <= 1'b0;
		wait_for(2, ST + 10);
		chk({hit, result[3:0]}, {1'b1, r1[3:0]}, "next channel");
		$display("alternate sync done");
		wrap_up();
	end
	initial cycles = 0;
	initial errors = 0;
	initial n_compared = 0;
endmodule : conversion_sync_and_fault_flags_tb_top
`default_nettype wire

// file: sim/csf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// host side of the align strobe
// ----
module csf_host_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic hold_low,
	input wire logic kick,
	input wire logic [7:0] len,
	output logic align_n
);
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	// a zero length still gives one full clock low
	assign cnt_d = kick ? ((len == 8'h00) ? 8'h01 : len)
		: ((cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q);
	// changes only after a rising edge, so release lands on one too
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 8'h00;
			align_n <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			align_n <= !(hold_low || kick || cnt_q > 8'h01);
		end
	end
endmodule : csf_host_model
`default_nettype wire
